//--- vcode_stepper_consts.vh
// Constants for the voltage-select code stepper
`ifndef VCODE_STEPPER_CONSTS_VH
`define VCODE_STEPPER_CONSTS_VH
`define CLK_SYS_HZ        50000000
`define SAMPLE_HZ         5550000
`define STEP_HZ           1850000
// Rounded down so the sample period is 180ns and the step period 540ns
`define SAMPLE_DIV        5'h09
`define STEP_DIV          5'h1b
`define DIV_W             5
`define CODE_W            8
`define CODE_STABLE_CNT   3'h3
`define OFF_STABLE_CNT    3'h4
`define CNT_W             3
`define OFF_CODE_A        8'hfe
`define OFF_CODE_B        8'hff
`define LOWEST_CODE       8'hb2
`define DAC_RESET_CODE    8'h00
`endif

//--- tick_divider.v
// Free-running divider that emits one-cycle ticks
`timescale 1ns/1ps
`include "vcode_stepper_consts.vh"
module tick_divider
#(
   parameter [`DIV_W-1:0] DIV = 5'h01
)
(
   // Clock and reset
   input  wire clk_sys,
   input  wire rst_b,
   // Tick out
   output reg  tick_ff
);
   reg [`DIV_W-1:0] cnt_ff;
   wire             wrap = (cnt_ff == DIV - 5'h01);

   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_ff  <= 5'h00;
         tick_ff <= 1'b0;
      end
      else
      begin
         cnt_ff  <= wrap ? 5'h00 : cnt_ff + 5'h01;
         tick_ff <= wrap;
      end
   end
endmodule

//--- voltage_code_dac_stepper.v
// Voltage-select code debounce, DAC stepping and off-code latch
//
// What this block does
// RQ1: Sample the code each 5.55MHz tick and compare against the target code.
// RQ2: Accept a differing code after three consecutive equal samples.
// RQ3: Step the DAC one 6.25mV code toward target each 1.85MHz tick.
// RQ4: Keep stepping until DAC equals target, then stop.
// RQ5: Recognise an off code after four consecutive equal samples.
// RQ6: Off code latches regulation off until enable falls then rises.
// RQ7: Higher code means lower level; codes fe and ff mean off.
// RQ8: A code change restarts the count; ramp retargets to the new code.
`timescale 1ns/1ps
`include "vcode_stepper_consts.vh"
module voltage_code_dac_stepper
(
   // Clock and reset
   input  wire                clk_sys,
   input  wire                rst_b,
   // Pins from the microprocessor and system
   input  wire [`CODE_W-1:0]  voltage_select_code,
   input  wire                enable_in,
   // DAC and regulation control
   output reg  [`CODE_W-1:0]  dac_code_ff,
   output reg  [`CODE_W-1:0]  target_code_ff,
   output reg                 ramping_ff,
   output reg                 reg_enable_ff,
   output reg                 off_latched_ff
);
   function is_off;
      input [`CODE_W-1:0] c;
      begin
         is_off = (c == `OFF_CODE_A) || (c == `OFF_CODE_B);
      end
   endfunction

   reg  [`CODE_W-1:0] code_s1_ff;
   reg  [`CODE_W-1:0] code_s2_ff;
   reg                en_s1_ff;
   reg                en_s2_ff;
   reg                en_prev_ff;
   reg                en_low_seen_ff;
   reg  [`CODE_W-1:0] sample_ff;
   reg  [`CNT_W-1:0]  stable_cnt_ff;
   reg                accepted_ff;
   wire               sample_tick;
   wire               step_tick;

   tick_divider #(.DIV(`SAMPLE_DIV)) u_sample_div
   (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tick_ff (sample_tick)
   );

   tick_divider #(.DIV(`STEP_DIV)) u_step_div
   (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tick_ff (step_tick)
   );

   // Pin synchronisers
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         code_s1_ff <= `DAC_RESET_CODE;
         code_s2_ff <= `DAC_RESET_CODE;
         en_s1_ff   <= 1'b0;
         en_s2_ff   <= 1'b0;
         en_prev_ff <= 1'b0;
      end
      else
      begin
         code_s1_ff <= voltage_select_code;
         code_s2_ff <= code_s1_ff;
         en_s1_ff   <= enable_in;
         en_s2_ff   <= en_s1_ff;
         en_prev_ff <= en_s2_ff;
      end
   end

   // One DAC code per step toward the target; a higher code is a lower level
   function [`CODE_W-1:0] step_toward;
      input [`CODE_W-1:0] cur;
      input [`CODE_W-1:0] tgt;
      begin
         if (cur < tgt)
            step_toward = cur + 8'h01;
         else if (cur > tgt)
            step_toward = cur - 8'h01;
         else
            step_toward = cur;
      end
   endfunction

   // Sample comparison and enable edge
   wire               same_sample = (code_s2_ff == sample_ff);
   wire               sample_off  = is_off(code_s2_ff);
   wire               differs     = (code_s2_ff != target_code_ff);
   wire               en_rise     = en_s2_ff && !en_prev_ff;

   // Combinational next values
   reg  [`CNT_W-1:0]  run_len;
   reg                hit_code;
   reg                hit_off;
   reg  [`CODE_W-1:0] nxt_sample;
   reg  [`CNT_W-1:0]  nxt_cnt;
   reg  [`CODE_W-1:0] nxt_target;
   reg                nxt_accepted;
   reg                nxt_off_latched;
   reg                nxt_en_low_seen;
   reg                nxt_reg_enable;
   reg  [`CODE_W-1:0] nxt_dac;
   reg                nxt_ramping;

   // Debounce and acceptance; a differing sample restarts the run at one
   always @*
   begin
      run_len      = same_sample ? stable_cnt_ff + 3'h1 : 3'h1;
      hit_code     = !sample_off && differs && (run_len == `CODE_STABLE_CNT);
      hit_off      = sample_off && (run_len == `OFF_STABLE_CNT);
      nxt_sample   = sample_ff;
      nxt_cnt      = stable_cnt_ff;
      nxt_target   = target_code_ff;
      nxt_accepted = accepted_ff;
      if (off_latched_ff)
      begin
         // Codes are ignored while latched; the run restarts once cleared
         nxt_sample = code_s2_ff;
         nxt_cnt    = 3'h0;
      end
      else if (sample_tick)                                       // [RQ1]
      begin
         nxt_sample = code_s2_ff;
         // Saturate so an off code latches only once
         if (!(stable_cnt_ff == `OFF_STABLE_CNT && same_sample))
            nxt_cnt = run_len;                                    // [RQ8]
         if (hit_code)
         begin
            nxt_target   = code_s2_ff;                            // [RQ2] [RQ8]
            nxt_accepted = 1'b1;
         end
      end
   end

   // Off latch: clears only after enable low then a rising edge
   always @*
   begin
      nxt_off_latched = off_latched_ff;
      nxt_en_low_seen = en_low_seen_ff;
      if (sample_tick && hit_off)
      begin
         // Set wins over a clear in the same cycle
         nxt_off_latched = 1'b1;                                  // [RQ5] [RQ6]
         nxt_en_low_seen = 1'b0;
      end
      else if (off_latched_ff && !en_s2_ff)
         nxt_en_low_seen = 1'b1;
      else if (off_latched_ff && en_low_seen_ff && en_rise)
      begin
         nxt_off_latched = 1'b0;                                  // [RQ6]
         nxt_en_low_seen = 1'b0;
      end
      nxt_reg_enable = en_s2_ff && !nxt_off_latched;
   end

   // DAC stepping; the DAC freezes while latched off
   always @*
   begin
      nxt_dac     = dac_code_ff;
      nxt_ramping = accepted_ff && !off_latched_ff && (dac_code_ff != target_code_ff);
      if (step_tick && accepted_ff && !off_latched_ff)            // [RQ3]
         nxt_dac = step_toward(dac_code_ff, target_code_ff);      // [RQ4] [RQ7]
   end

   // Debounce registers
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sample_ff      <= `DAC_RESET_CODE;
         stable_cnt_ff  <= 3'h0;
         accepted_ff    <= 1'b0;
         target_code_ff <= `DAC_RESET_CODE;
      end
      else
      begin
         sample_ff      <= nxt_sample;
         stable_cnt_ff  <= nxt_cnt;
         accepted_ff    <= nxt_accepted;
         target_code_ff <= nxt_target;
      end
   end

   // Off latch registers
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         off_latched_ff <= 1'b0;
         en_low_seen_ff <= 1'b0;
         reg_enable_ff  <= 1'b0;
      end
      else
      begin
         off_latched_ff <= nxt_off_latched;
         en_low_seen_ff <= nxt_en_low_seen;
         reg_enable_ff  <= nxt_reg_enable;
      end
   end

   // DAC registers
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         dac_code_ff <= `DAC_RESET_CODE;
         ramping_ff  <= 1'b0;
      end
      else
      begin
         dac_code_ff <= nxt_dac;
         ramping_ff  <= nxt_ramping;
      end
   end
endmodule

//--- vcs_properties.sv
// Checker bound to the code stepper
`timescale 1ns/1ps
module vcs_properties
(
   input wire       clk_sys,
   input wire       rst_b,
   input wire [7:0] voltage_select_code,
   input wire       enable_in,
   input wire [7:0] dac_code_ff,
   input wire [7:0] target_code_ff,
   input wire       ramping_ff,
   input wire       reg_enable_ff,
   input wire       off_latched_ff
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence quiet_dac;
      $stable(dac_code_ff)[*8];
   endsequence
   a_step_by_one: assert property ($changed(dac_code_ff) |->
      dac_code_ff == ($past(dac_code_ff) < $past(target_code_ff) ? $past(dac_code_ff) + 8'h01
      : $past(dac_code_ff) - 8'h01)) else $error("bad step");
   a_step_gap: assert property ($changed(dac_code_ff) |=> quiet_dac) else $error("steps too close");
   a_stop_at_target: assert property (dac_code_ff == target_code_ff |=> $stable(dac_code_ff))
      else $error("moved past target");
   a_ramp_clear: assert property ((dac_code_ff == target_code_ff)[*2] |-> !ramping_ff)
      else $error("ramping while equal");
   a_target_legal: assert property ($changed(target_code_ff) |-> !(target_code_ff inside {8'hfe, 8'hff})
      && target_code_ff == $past(voltage_select_code, 5) && target_code_ff == $past(voltage_select_code, 20))
      else $error("bad acceptance");
   a_off_cause: assert property ($rose(off_latched_ff) |-> $past(voltage_select_code, 5) inside {8'hfe, 8'hff}
      && $past(voltage_select_code, 30) == $past(voltage_select_code, 5)) else $error("bad off latch");
   a_off_holds: assert property (enable_in[*6] ##0 off_latched_ff |=> off_latched_ff)
      else $error("off cleared without toggle");
   a_off_blocks: assert property (off_latched_ff && $past(off_latched_ff) |-> !reg_enable_ff
      && $stable(dac_code_ff) && $stable(target_code_ff)) else $error("active while off");
   // Steps come from a free-running 540ns tick, so any two are a whole number of periods apart
   localparam int STEP_CLKS = 27;
   reg [7:0]  prev_dac_ff;
   reg [15:0] gap_ff;
   reg        seen_ff;
   always @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         prev_dac_ff <= 8'h00;
         gap_ff      <= 16'h0000;
         seen_ff     <= 1'b0;
      end
      else
      begin
         prev_dac_ff <= dac_code_ff;
         if (dac_code_ff != prev_dac_ff)
         begin
            gap_ff  <= 16'h0000;
            seen_ff <= 1'b1;
         end
         else if (gap_ff != 16'hffff)
            gap_ff <= gap_ff + 16'h0001;
      end
   end
   a_step_period: assert property ($changed(dac_code_ff) && seen_ff |-> ((gap_ff + 1) % STEP_CLKS) == 0)
      else $error("step period wrong");
endmodule
bind voltage_code_dac_stepper vcs_properties vcs_properties_i (.clk_sys(clk_sys), .rst_b(rst_b),
   .voltage_select_code(voltage_select_code), .enable_in(enable_in), .dac_code_ff(dac_code_ff),
   .target_code_ff(target_code_ff), .ramping_ff(ramping_ff), .reg_enable_ff(reg_enable_ff),
   .off_latched_ff(off_latched_ff));

//--- vcode_host_model.sv
// Host side model driving the code and enable pins
`timescale 1ns/1ps
module vcode_host_model
(
   input  wire       clk_sys,
   input  wire [7:0] want_code,
   input  wire       want_en,
   output reg  [7:0] code_ff = 8'h00,
   output reg        en_ff = 1'b0
);
   always @(posedge clk_sys)
   begin
      code_ff <= want_code;
      en_ff <= want_en;
   end
endmodule

//--- tb.sv
// Self-checking bench for the code stepper
`timescale 1ns/1ps
module tb;
   reg        clk_sys = 1'b0;
   reg        rst_b = 1'b0;
   reg  [7:0] want_code = 8'h00;
   reg        want_en = 1'b0;
   wire [7:0] code, dac, tgt;
   wire       en, ramp, reg_en, off;
   integer    n_errors = 0;
   integer    n_compared = 0;
   integer    i;
   reg  [7:0] rows [0:3] = '{8'h04, 8'h02, 8'hb2, 8'h10};
   vcode_host_model vcode_host_model_i (.clk_sys(clk_sys), .want_code(want_code), .want_en(want_en),
      .code_ff(code), .en_ff(en));
   voltage_code_dac_stepper voltage_code_dac_stepper_i (.clk_sys(clk_sys), .rst_b(rst_b),
      .voltage_select_code(code), .enable_in(en), .dac_code_ff(dac), .target_code_ff(tgt),
      .ramping_ff(ramp), .reg_enable_ff(reg_en), .off_latched_ff(off));
   initial
   begin
      forever #10 clk_sys = ~clk_sys;
   end
   task chk(input string n, input [7:0] e, input [7:0] g);
   begin
      n_compared = n_compared + 1;
      if (g !== e)
      begin
         n_errors = n_errors + 1;
         $display("[ERR] %0s expected %h seen %h", n, e, g);
      end
   end
   endtask
   task end_of_test;
   begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task set(input [7:0] c, input integer n);
   begin
      @(posedge clk_sys) want_code <= c;
      repeat (n) @(negedge clk_sys);
   end
   endtask
   // Waits for the ramp to land, bounded
   task go(input [7:0] c);
      integer k;
   begin
      set(c, 40);
      for (k = 0; k < 6000 && dac !== c; k = k + 1)
         @(negedge clk_sys);
      repeat (2) @(negedge clk_sys);
   end
   endtask
   initial
   begin
      #1000000;
      n_errors = n_errors + 1;
      end_of_test;
   end
   initial
   begin
      repeat (9) @(posedge clk_sys);
      @(negedge clk_sys);
      chk("dac", 8'h00, dac);
      chk("off", 8'h00, off);
      @(posedge clk_sys) rst_b <= 1'b1;
      want_en <= 1'b1;
      for (i = 0; i < 4; i = i + 1)
      begin
         go(rows[i]);
         chk("dac", rows[i], dac);
         chk("tgt", rows[i], tgt);
         chk("ramp", 8'h00, ramp);
      end
      set(8'h20, 12);
      set(8'h10, 80);
      chk("tgt", 8'h10, tgt);
      set(8'h20, 150);
      go(8'h12);
      chk("dac", 8'h12, dac);
      set(8'hfe, 25);
      set(8'h12, 80);
      chk("off", 8'h00, off);
      for (i = 0; i < 2; i = i + 1)
      begin
         set(8'hfe + i, 50);
         chk("off", 8'h01, off);
         set(8'h30, 60);
         chk("reg_en", 8'h00, reg_en);
         @(posedge clk_sys) want_en <= 1'b0;
         set(8'h30, 10);
         @(posedge clk_sys) want_en <= 1'b1;
         set(8'h30, 10);
         chk("reg_en", 8'h01, reg_en);
      end
      @(posedge clk_sys) rst_b <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("dac", 8'h00, dac);
      chk("tgt", 8'h00, tgt);
      chk("reg_en", 8'h00, reg_en);
      @(posedge clk_sys) rst_b <= 1'b1;
      go(8'h30);
      chk("dac", 8'h30, dac);
      chk("tgt", 8'h30, tgt);
      end_of_test;
   end
endmodule
